// File: core/vic_pkg.sv
// shared constants and types for the vectored interrupt controller
// Overview of operation
// - vector upper nibble comes from software register
// - vector low nibble is winning channel number
// - vector register at 17h, nibble, select, zeros
// - nibble bits written by processor, reset clears
// - select zero auto end, one software end
// - idle in chain passes enable downstream
// - requesting device answers, holds chain output negated
// - shared acknowledge, every device resolves concurrently
// - sixteen channels: eight external, eight internal
// - enable registers written, readable, reset cleared
// - disabled channel ignores events, keeps nothing pending
// - enabled, unmasked channel event raises request output
// - disabling clears pending, withdraws its request
// - disabling leaves in-service bit untouched
// - pending registers at 0Bh, 0Dh, fixed layout
// - event on enabled channel sets pending
// - pending clears on delivery, disable, zero, reset
// - in-service at 0Fh, 11h, zero write clears
// - mask bits: zero masks, one unmasks
// - channel fifteen highest, channel zero lowest
// - software mode delivery sets in-service bit
// - in-service blocks itself and lower channels
// - writing ones to pending changes nothing
package vic_pkg;
	localparam int CH_N = 16;
	localparam logic [4:0] ADDR_EN_HI = 5'h01;
	localparam logic [4:0] ADDR_EN_LO = 5'h03;
	localparam logic [4:0] ADDR_MASK_HI = 5'h05;
	localparam logic [4:0] ADDR_MASK_LO = 5'h07;
	localparam logic [4:0] ADDR_PEND_HI = 5'h0B;
	localparam logic [4:0] ADDR_PEND_LO = 5'h0D;
	localparam logic [4:0] ADDR_INSV_HI = 5'h0F;
	localparam logic [4:0] ADDR_INSV_LO = 5'h11;
	localparam logic [4:0] ADDR_VEC = 5'h17;
	localparam int VEC_NIB_MSB = 7;
	localparam int VEC_NIB_LSB = 4;
	localparam int VEC_SEL_BIT = 3;
	localparam logic [2:0] VEC_UNUSED_RD = 3'h0;
	localparam logic [3:0] NIB_RST = 4'h0;
	localparam logic SEL_RST = 1'b0;
	localparam logic [15:0] CH_RST = 16'h0000;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam int CH_TIMER_A = 13;
	localparam int CH_RX_FULL = 12;
	localparam int CH_RX_ERR = 11;
	localparam int CH_TX_EMPTY = 10;
	localparam int CH_TX_ERR = 9;
	localparam int CH_TIMER_B = 8;
	localparam int CH_TIMER_C = 5;
	localparam int CH_TIMER_D = 4;
	localparam int GP_CH [8] = '{0, 1, 2, 3, 6, 7, 14, 15};

	typedef struct packed {
		logic timer_a;
		logic rx_full;
		logic rx_err;
		logic tx_empty;
		logic tx_err;
		logic timer_b;
		logic timer_c;
		logic timer_d;
	} vic_src_t;

	typedef struct packed {
		logic reg_rd;
		logic reg_wr;
		logic ack_take;
	} vic_stb_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_REG,
		ST_ACK_WAIT,
		ST_ACK_DRIVE,
		ST_PASS
	} vic_bus_st_t;
endpackage

// File: core/vic_prio.sv
// fixed-priority resolver with in-service blocking
module vic_prio (
	input wire logic [vic_pkg::CH_N-1:0] cand,
	input wire logic [vic_pkg::CH_N-1:0] insv,
	output logic found,
	output logic [3:0] code
);
	logic [vic_pkg::CH_N-1:0] elig;

	// a set in-service bit blocks its own and every lower channel
	for (genvar i = 0; i < vic_pkg::CH_N; i++) begin : g_elig
		assign elig[i] = cand[i] & ~(|insv[vic_pkg::CH_N-1:i]);
	end

	// highest index wins; purely combinational, so chained parts resolve in parallel
	always_comb begin
		found = 1'b0;
		code = 4'h0;
		for (int i = 0; i < vic_pkg::CH_N; i++) begin
			if (elig[i]) begin
				found = 1'b1;
				code = 4'(i);
			end
		end
	end
endmodule

// File: core/vic_bus.sv
// register and acknowledge cycle sequencer with chain handling
module vic_bus (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic ds_n,
	input wire logic rw,
	input wire logic vector_acknowledge_n,
	input wire logic chain_enable_in_n,
	input wire logic respond,
	output vic_pkg::vic_stb_t stb,
	output logic data_oe,
	output logic dtack_n,
	output logic dtack_oe,
	output logic chain_enable_out_n
);
	vic_pkg::vic_bus_st_t state_reg, state_next;
	logic rd_reg;
	logic reg_cyc, ack_cyc;

	assign reg_cyc = !cs_n && !ds_n && vector_acknowledge_n;
	assign ack_cyc = !vector_acknowledge_n && !ds_n;

	always_comb begin
		state_next = state_reg;
		stb = '0;
		unique case (state_reg)
			vic_pkg::ST_IDLE: begin
				if (ack_cyc) begin
					state_next = vic_pkg::ST_ACK_WAIT;
				end else if (reg_cyc) begin
					state_next = vic_pkg::ST_REG;
					stb.reg_rd = rw;
					stb.reg_wr = !rw;
				end
			end
			vic_pkg::ST_REG: begin
				if (!reg_cyc) state_next = vic_pkg::ST_IDLE;
			end
			vic_pkg::ST_ACK_WAIT: begin
				if (!ack_cyc) begin
					state_next = vic_pkg::ST_IDLE;
				end else if (!chain_enable_in_n) begin
					if (respond) begin
						stb.ack_take = 1'b1;
						state_next = vic_pkg::ST_ACK_DRIVE;
					end else begin
						state_next = vic_pkg::ST_PASS;
					end
				end
			end
			vic_pkg::ST_ACK_DRIVE, vic_pkg::ST_PASS: begin
				if (!ack_cyc) state_next = vic_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= vic_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_reg <= 1'b0;
		end else if (stb.reg_rd || stb.reg_wr) begin
			rd_reg <= stb.reg_rd;
		end
	end

	assign dtack_oe = (state_reg == vic_pkg::ST_REG) || (state_reg == vic_pkg::ST_ACK_DRIVE);
	assign dtack_n = !dtack_oe;
	assign data_oe = ((state_reg == vic_pkg::ST_REG) && rd_reg)
		|| (state_reg == vic_pkg::ST_ACK_DRIVE);
	// passing the chain never drives data or acknowledge
	assign chain_enable_out_n = (state_reg != vic_pkg::ST_PASS);
endmodule

// File: core/vic_top.sv
// sixteen-channel vectored interrupt controller top
module vic_top (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic ds_n,
	input wire logic rw,
	input wire logic [4:0] reg_sel,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic dtack_n,
	output logic dtack_oe,
	input wire logic vector_acknowledge_n,
	input wire logic chain_enable_in_n,
	output logic chain_enable_out_n,
	output logic service_request_n,
	input wire logic [7:0] general_input_line,
	input wire vic_pkg::vic_src_t src_event
);
	logic [15:0] en_reg, en_next;
	logic [15:0] mask_reg;
	logic [15:0] pend_reg, pend_next, pend_clr;
	logic [15:0] insv_reg, insv_next, insv_clr;
	logic [15:0] evt, ack_hot, cand;
	logic [3:0] nib_reg;
	logic sel_reg;
	logic [7:0] dout_reg, rdata;
	logic irq_reg;
	logic found;
	logic [3:0] code;
	logic wr_pend_hi, wr_pend_lo, wr_insv_hi, wr_insv_lo;
	logic wr_en_hi, wr_en_lo, wr_mask_hi, wr_mask_lo, wr_vec;
	vic_pkg::vic_stb_t stb;

	vic_bus u_bus (
		.mclk(mclk),
		.arst_n(arst_n),
		.cs_n(cs_n),
		.ds_n(ds_n),
		.rw(rw),
		.vector_acknowledge_n(vector_acknowledge_n),
		.chain_enable_in_n(chain_enable_in_n),
		.respond(found),
		.stb(stb),
		.data_oe(data_oe),
		.dtack_n(dtack_n),
		.dtack_oe(dtack_oe),
		.chain_enable_out_n(chain_enable_out_n)
	);

	vic_prio u_prio (
		.cand(cand),
		.insv(insv_reg),
		.found(found),
		.code(code)
	);

	// write decode
	assign wr_en_hi = stb.reg_wr && (reg_sel == vic_pkg::ADDR_EN_HI);
	assign wr_en_lo = stb.reg_wr && (reg_sel == vic_pkg::ADDR_EN_LO);
	assign wr_mask_hi = stb.reg_wr && (reg_sel == vic_pkg::ADDR_MASK_HI);
	assign wr_mask_lo = stb.reg_wr && (reg_sel == vic_pkg::ADDR_MASK_LO);
	assign wr_pend_hi = stb.reg_wr && (reg_sel == vic_pkg::ADDR_PEND_HI);
	assign wr_pend_lo = stb.reg_wr && (reg_sel == vic_pkg::ADDR_PEND_LO);
	assign wr_insv_hi = stb.reg_wr && (reg_sel == vic_pkg::ADDR_INSV_HI);
	assign wr_insv_lo = stb.reg_wr && (reg_sel == vic_pkg::ADDR_INSV_LO);
	assign wr_vec = stb.reg_wr && (reg_sel == vic_pkg::ADDR_VEC);

	// event sources onto channel numbers
	always_comb begin
		evt = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			evt[vic_pkg::GP_CH[i]] = general_input_line[i];
		end
		evt[vic_pkg::CH_TIMER_A] = src_event.timer_a;
		evt[vic_pkg::CH_RX_FULL] = src_event.rx_full;
		evt[vic_pkg::CH_RX_ERR] = src_event.rx_err;
		evt[vic_pkg::CH_TX_EMPTY] = src_event.tx_empty;
		evt[vic_pkg::CH_TX_ERR] = src_event.tx_err;
		evt[vic_pkg::CH_TIMER_B] = src_event.timer_b;
		evt[vic_pkg::CH_TIMER_C] = src_event.timer_c;
		evt[vic_pkg::CH_TIMER_D] = src_event.timer_d;
	end

	// enable after this cycle's write
	always_comb begin
		en_next = en_reg;
		if (wr_en_hi) en_next[15:8] = data_in;
		if (wr_en_lo) en_next[7:0] = data_in;
	end

	// zero bits in a write clear, ones leave alone
	always_comb begin
		pend_clr = 16'h0000;
		insv_clr = 16'h0000;
		if (wr_pend_hi) pend_clr[15:8] = ~data_in;
		if (wr_pend_lo) pend_clr[7:0] = ~data_in;
		if (wr_insv_hi) insv_clr[15:8] = ~data_in;
		if (wr_insv_lo) insv_clr[7:0] = ~data_in;
	end

	assign ack_hot = stb.ack_take ? (16'h0001 << code) : 16'h0000;

	// new events win over clears; disabled channels hold nothing
	assign pend_next = ((pend_reg & ~pend_clr & ~ack_hot) | evt) & en_next;

	// auto mode keeps in-service forced low; disabling does not touch it
	assign insv_next = sel_reg ? ((insv_reg & ~insv_clr) | ack_hot) : 16'h0000;

	assign cand = pend_reg & mask_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			en_reg <= vic_pkg::CH_RST;
		end else begin
			en_reg <= en_next;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mask_reg <= vic_pkg::CH_RST;
		end else begin
			if (wr_mask_hi) mask_reg[15:8] <= data_in;
			if (wr_mask_lo) mask_reg[7:0] <= data_in;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg <= vic_pkg::CH_RST;
		end else begin
			pend_reg <= pend_next;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			insv_reg <= vic_pkg::CH_RST;
		end else begin
			insv_reg <= insv_next;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			nib_reg <= vic_pkg::NIB_RST;
			sel_reg <= vic_pkg::SEL_RST;
		end else if (wr_vec) begin
			nib_reg <= data_in[vic_pkg::VEC_NIB_MSB:vic_pkg::VEC_NIB_LSB];
			sel_reg <= data_in[vic_pkg::VEC_SEL_BIT];
		end
	end

	// read mux
	always_comb begin
		case (reg_sel)
			vic_pkg::ADDR_EN_HI: rdata = en_reg[15:8];
			vic_pkg::ADDR_EN_LO: rdata = en_reg[7:0];
			vic_pkg::ADDR_MASK_HI: rdata = mask_reg[15:8];
			vic_pkg::ADDR_MASK_LO: rdata = mask_reg[7:0];
			vic_pkg::ADDR_PEND_HI: rdata = pend_reg[15:8];
			vic_pkg::ADDR_PEND_LO: rdata = pend_reg[7:0];
			vic_pkg::ADDR_INSV_HI: rdata = insv_reg[15:8];
			vic_pkg::ADDR_INSV_LO: rdata = insv_reg[7:0];
			vic_pkg::ADDR_VEC: rdata = {nib_reg, sel_reg, vic_pkg::VEC_UNUSED_RD};
			default: rdata = vic_pkg::RD_UNMAPPED;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dout_reg <= 8'h00;
		end else if (stb.ack_take) begin
			dout_reg <= {nib_reg, code};
		end else if (stb.reg_rd) begin
			dout_reg <= rdata;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= found;
		end
	end

	assign data_out = dout_reg;
	assign service_request_n = !irq_reg;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	AST_VECTOR_FORMAT:
	assert property (stb.ack_take |=> dout_reg == {$past(nib_reg), $past(code)})
		else $error("vector not formed from nibble and channel");

	AST_VEC_LOW_ZERO:
	assert property ((stb.reg_rd && reg_sel == vic_pkg::ADDR_VEC) |=> dout_reg[2:0] == 3'h0)
		else $error("vector register low bits not zero");

	AST_NIB_WRITE:
	assert property (wr_vec |=> nib_reg == $past(data_in[7:4]) ##1 nib_reg == $past(nib_reg))
		else $error("vector nibble not stored");

	AST_AUTO_EOI:
	assert property (!sel_reg |=> insv_reg == 16'h0000)
		else $error("in-service set in automatic mode");

	AST_CHAIN_PASS:
	assert property ($fell(chain_enable_out_n) |-> $past(!chain_enable_in_n && !found))
		else $error("chain passed while requesting or not enabled");

	AST_CHAIN_EXCLUSIVE:
	assert property (!chain_enable_out_n |-> !data_oe && !dtack_oe)
		else $error("device drives bus while passing chain");

	AST_ACK_DRIVE:
	assert property (stb.ack_take |=> data_oe && dtack_oe && chain_enable_out_n)
		else $error("no vector driven after acknowledge taken");

	AST_DISABLED_EMPTY:
	assert property ((pend_reg & ~en_reg) == 16'h0000)
		else $error("pending bit on disabled channel");

	AST_EVENT_SETS:
	assert property ((|(evt & en_next)) |=> (|pend_reg))
		else $error("enabled event left no pending bit");

	AST_IRQ_FOLLOWS:
	assert property (found |=> !service_request_n ##0 $past(found))
		else $error("request output does not track resolver");

	AST_IRQ_IDLE:
	assert property (!found |=> service_request_n)
		else $error("request asserted with nothing eligible");

	AST_ACK_CLEARS:
	assert property ((stb.ack_take && !(|(evt & ack_hot))) |=> (pend_reg & $past(ack_hot)) == 16'h0)
		else $error("delivered channel still pending");

	AST_SW_EOI_SET:
	assert property ((stb.ack_take && sel_reg) |=> (|(insv_reg & $past(ack_hot))))
		else $error("in-service not set on delivery");

	AST_INSV_HOLD:
	assert property ((sel_reg && !wr_insv_hi && !wr_insv_lo && !wr_vec)
		|=> (($past(insv_reg) & ~insv_reg) == 16'h0))
		else $error("in-service bit lost without a write");

	AST_PEND_ONES:
	assert property ((wr_pend_hi && data_in == 8'hFF) |=> ($past(pend_reg[15:8]) & ~pend_reg[15:8]) == 8'h00)
		else $error("writing ones changed pending bits");

	AST_ACK_ELIGIBLE:
	assert property (stb.ack_take |-> cand[code])
		else $error("vector taken for a channel not pending and unmasked");

	AST_ACK_UNBLOCKED:
	assert property (stb.ack_take |-> (insv_reg >> code) == 16'h0000)
		else $error("vector taken at or below an in-service channel");

	AST_ACK_HIGHEST:
	assert property (stb.ack_take |-> (cand >> code) == 16'h0001)
		else $error("vector taken while a higher channel waits");

	AST_EN_WRITE:
	assert property (wr_en_hi |=> en_reg[15:8] == $past(data_in))
		else $error("enable write not stored");

	AST_MASK_WRITE:
	assert property (wr_mask_lo |=> mask_reg[7:0] == $past(data_in))
		else $error("mask write not stored");

	AST_EN_KEEPS_INSV:
	assert property (((wr_en_hi || wr_en_lo) && sel_reg) |=> insv_reg == $past(insv_reg))
		else $error("enable write changed in-service bits");

	AST_PEND_ZERO:
	assert property (wr_pend_lo
		|=> (pend_reg[7:0] & ~$past(data_in) & ~$past(evt[7:0])) == 8'h00)
		else $error("zero write left pending bit set");

	AST_EVENT_BITS:
	assert property ((|(evt & en_next))
		|=> (pend_reg & $past(evt & en_next)) == $past(evt & en_next))
		else $error("enabled event bit not pending");

	AST_SEL_WRITE:
	assert property (wr_vec |=> sel_reg == $past(data_in[vic_pkg::VEC_SEL_BIT]))
		else $error("end-of-interrupt select not stored");

	AST_READ_PEND:
	assert property ((stb.reg_rd && reg_sel == vic_pkg::ADDR_PEND_HI)
		|=> dout_reg == $past(pend_reg[15:8]))
		else $error("pending read data wrong");

	AST_READ_INSV:
	assert property ((stb.reg_rd && reg_sel == vic_pkg::ADDR_INSV_LO)
		|=> dout_reg == $past(insv_reg[7:0]))
		else $error("in-service read data wrong");

	AST_READ_EN:
	assert property ((stb.reg_rd && reg_sel == vic_pkg::ADDR_EN_LO)
		|=> dout_reg == $past(en_reg[7:0]))
		else $error("enable read data wrong");

	COV_SW_EOI: cover property (stb.ack_take && sel_reg);
	COV_PASS: cover property ($fell(chain_enable_out_n));
	COV_TWO_ACKS: cover property (stb.ack_take ##[1:40] stb.ack_take);
	COV_NEST_BLOCK: cover property ((|insv_reg) && (|cand) && !found);
endmodule

// File: test/vic_host.sv
// host bus and upstream chain peer model
module vic_host (
	input wire logic mclk,
	output logic cs_n,
	output logic ds_n,
	output logic rw,
	output logic [4:0] reg_sel,
	output logic [7:0] data_in,
	output logic vector_acknowledge_n,
	output logic chain_enable_in_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic dtack_n,
	input wire logic dtack_oe,
	input wire logic chain_enable_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b1;
		ds_n = 1'b1;
		rw = 1'b1;
		reg_sel = 5'h00;
		data_in = 8'h00;
		vector_acknowledge_n = 1'b1;
		chain_enable_in_n = 1'b1;
	end
	// ans: 0 no answer, 1 acknowledged, 2 passed down the chain
	task automatic cyc(input logic ack, input logic rd, input logic [4:0] a,
			input logic [7:0] d, input logic cin, input int hold,
			output logic [7:0] q, output int ans);
		ans = 0;
		q = 8'h00;
		@(negedge mclk);
		vector_acknowledge_n = ~ack;
		cs_n = ack;
		rw = rd | ack;
		reg_sel = a;
		data_in = d;
		chain_enable_in_n = cin;
		ds_n = 1'b0;
		for (int n = 0; n < 12 && ans == 0; n++) begin
			@(posedge mclk);
			if (dtack_oe === 1'b1 && dtack_n === 1'b0) begin
				ans = 1;
				// undriven bus floats away from the last value
				q = data_oe ? data_out : ~data_out;
			end else if (ack && chain_enable_out_n === 1'b0) begin
				ans = 2;
			end
		end
		repeat (hold) @(negedge mclk);
		@(negedge mclk);
		ds_n = 1'b1;
		cs_n = 1'b1;
		vector_acknowledge_n = 1'b1;
		chain_enable_in_n = 1'b1;
		data_in = ~data_in;
		repeat (2) @(negedge mclk);
	endtask
endmodule

// File: test/vectored_interrupt_controller_bench.sv
// self-checking bench for the vectored interrupt controller
module vectored_interrupt_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, arst_n, cs_n, ds_n, rw, data_oe, dtack_n, dtack_oe;
	logic ack_n, cin_n, cout_n, sreq_n;
	logic [4:0] reg_sel;
	logic [7:0] data_in, data_out, gpi;
	vic_pkg::vic_src_t src;
	logic [3:0] nib;
	logic [15:0] ev;
	int err_total = 0;
	int checks = 0;
	int cyc_cnt = 0;

	vic_top dut_u (.mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .ds_n(ds_n), .rw(rw),
		.reg_sel(reg_sel), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.dtack_n(dtack_n), .dtack_oe(dtack_oe), .vector_acknowledge_n(ack_n),
		.chain_enable_in_n(cin_n), .chain_enable_out_n(cout_n),
		.service_request_n(sreq_n), .general_input_line(gpi), .src_event(src));
	vic_host host_u (.mclk(mclk), .cs_n(cs_n), .ds_n(ds_n), .rw(rw), .reg_sel(reg_sel),
		.data_in(data_in), .vector_acknowledge_n(ack_n), .chain_enable_in_n(cin_n),
		.data_out(data_out), .data_oe(data_oe), .dtack_n(dtack_n), .dtack_oe(dtack_oe),
		.chain_enable_out_n(cout_n));

	initial begin
		mclk = 1'b0;
	end
	always #20 mclk = ~mclk;

	task automatic finish_test();
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t pin %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		int ans;
		host_u.cyc(1'b0, 1'b0, a, d, 1'b1, 0, q, ans);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] q;
		int ans;
		host_u.cyc(1'b0, 1'b1, a, 8'h00, 1'b1, 1, q, ans);
		cmp8(q, exp);
	endtask
	// low half of each register pair sits two above the high half
	task automatic wr16(input logic [4:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 5'h02, v[7:0]);
	endtask
	task automatic rd16(input logic [4:0] a, input logic [15:0] exp);
		rd_chk(a, exp[15:8]);
		rd_chk(a + 5'h02, exp[7:0]);
	endtask
	task automatic ack(input logic cin, input int exp_ans, input logic [7:0] exp_v);
		logic [7:0] q;
		int ans;
		host_u.cyc(1'b1, 1'b1, 5'h00, 8'h00, cin, 0, q, ans);
		cmp8(8'(ans), 8'(exp_ans));
		if (exp_ans == 1)
			cmp8(q, exp_v);
	endtask
	task automatic pulse(input logic [15:0] c);
		@(negedge mclk);
		for (int i = 0; i < 8; i++)
			gpi[i] = c[vic_pkg::GP_CH[i]];
		src = {c[13], c[12], c[11], c[10], c[9], c[8], c[5], c[4]};
		@(negedge mclk);
		gpi = 8'h00;
		src = '0;
	endtask
	task automatic req_chk(input logic exp);
		repeat (3) @(negedge mclk);
		cmp1(sreq_n, exp);
	endtask
	function automatic logic [3:0] top_ch(input logic [15:0] v);
		top_ch = 4'h0;
		for (int i = 0; i < 16; i++)
			if (v[i])
				top_ch = 4'(i);
	endfunction

	initial begin
		arst_n = 1'b0;
		gpi = 8'h00;
		src = '0;
		void'($urandom(93));
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		arst_n = 1'b1;
		for (int a = 1; a < 19; a += 2)
			rd_chk(5'(a), 8'h00);
		rd_chk(vic_pkg::ADDR_VEC, 8'h00);
		cmp1(sreq_n, 1'b1);
		pulse(16'hFFFF);
		rd16(vic_pkg::ADDR_PEND_HI, 16'h0000);
		req_chk(1'b1);
		wr(vic_pkg::ADDR_VEC, 8'hFF);
		rd_chk(vic_pkg::ADDR_VEC, 8'hF8);
		wr(5'h1F, 8'hFF);
		rd_chk(5'h1F, 8'h00);
		wr16(vic_pkg::ADDR_EN_HI, 16'hFFFF);
		rd16(vic_pkg::ADDR_EN_HI, 16'hFFFF);
		wr16(vic_pkg::ADDR_MASK_HI, 16'hFFFF);
		rd16(vic_pkg::ADDR_MASK_HI, 16'hFFFF);
		for (int k = 0; k < 6; k++) begin
			nib = 4'($urandom);
			ev = (k == 0) ? 16'hFFFF : 16'($urandom);
			wr(vic_pkg::ADDR_VEC, {nib, 4'h0});
			pulse(ev);
			rd16(vic_pkg::ADDR_PEND_HI, ev);
			req_chk(ev == 16'h0000);
			if (ev != 16'h0000)
				ack(1'b1, 0, 8'h00);
			while (ev != 16'h0000) begin
				ack(1'b0, 1, {nib, top_ch(ev)});
				ev[top_ch(ev)] = 1'b0;
				rd16(vic_pkg::ADDR_PEND_HI, ev);
			end
			rd16(vic_pkg::ADDR_INSV_HI, 16'h0000);
			ack(1'b0, 2, 8'h00);
		end
		wr16(vic_pkg::ADDR_MASK_HI, 16'hFFFE);
		pulse(16'h0001);
		req_chk(1'b1);
		rd16(vic_pkg::ADDR_PEND_HI, 16'h0001);
		ack(1'b0, 2, 8'h00);
		wr16(vic_pkg::ADDR_MASK_HI, 16'hFFFF);
		req_chk(1'b0);
		wr16(vic_pkg::ADDR_PEND_HI, 16'hFFFF);
		rd16(vic_pkg::ADDR_PEND_HI, 16'h0001);
		wr16(vic_pkg::ADDR_PEND_HI, 16'hFFFE);
		rd16(vic_pkg::ADDR_PEND_HI, 16'h0000);
		req_chk(1'b1);
		wr(vic_pkg::ADDR_VEC, 8'h58);
		rd_chk(vic_pkg::ADDR_VEC, 8'h58);
		pulse(16'h0104);
		ack(1'b0, 1, 8'h58);
		rd16(vic_pkg::ADDR_INSV_HI, 16'h0100);
		req_chk(1'b1);
		ack(1'b0, 2, 8'h00);
		pulse(16'h8100);
		ack(1'b0, 1, 8'h5F);
		rd16(vic_pkg::ADDR_PEND_HI, 16'h0104);
		req_chk(1'b1);
		wr16(vic_pkg::ADDR_EN_HI, 16'hFEFF);
		rd16(vic_pkg::ADDR_PEND_HI, 16'h0004);
		rd16(vic_pkg::ADDR_INSV_HI, 16'h8100);
		wr16(vic_pkg::ADDR_INSV_HI, 16'h7FFF);
		rd16(vic_pkg::ADDR_INSV_HI, 16'h0100);
		wr(vic_pkg::ADDR_VEC, 8'h50);
		rd16(vic_pkg::ADDR_INSV_HI, 16'h0000);
		req_chk(1'b0);
		ack(1'b0, 1, 8'h52);
		req_chk(1'b1);
		wr(vic_pkg::ADDR_VEC, 8'hF8);
		pulse(16'h0004);
		ack(1'b0, 1, 8'hF2);
		pulse(16'h8001);
		rd16(vic_pkg::ADDR_INSV_HI, 16'h0004);
		req_chk(1'b0);
		// mid-run reset with live pending, in-service and vector state
		@(negedge mclk);
		arst_n = 1'b0;
		repeat (2) @(negedge mclk);
		arst_n = 1'b1;
		cmp1(sreq_n, 1'b1);
		for (int a = 1; a < 19; a += 2)
			rd_chk(5'(a), 8'h00);
		rd_chk(vic_pkg::ADDR_VEC, 8'h00);
		finish_test();
	end
endmodule
